// >>> verilog/aoc_params.svh
`ifndef AOC_PARAMS_SVH
`define AOC_PARAMS_SVH
// Register offsets on the byte-wide register port.
`define AOC_OFS_NVCTRL      8'h33
`define AOC_OFS_COMP_CTRL   8'h36
`define AOC_OFS_COMP_SETUP  8'h37
`define AOC_OFS_TRIM_X      8'h38
`define AOC_OFS_TRIM_Y      8'h39
`define AOC_OFS_TRIM_Z      8'h3a
`define AOC_OFS_SPARE0      8'h3b
`define AOC_OFS_SPARE1      8'h3c
// Field positions in the nonvolatile control register.
`define AOC_NV_UNLOCK       0
`define AOC_NV_TRIG         1
`define AOC_NV_RDY          2
`define AOC_NV_LOAD         3
`define AOC_NV_REMAIN_LO    4
// Field positions in the compensation control register.
`define AOC_CC_SLOW_X       0
`define AOC_CC_SLOW_Y       1
`define AOC_CC_SLOW_Z       2
`define AOC_CC_READY        4
`define AOC_CC_TRIG_LO      5
`define AOC_CC_CLEAR        7
// Field positions in the compensation setup register.
`define AOC_CS_CORNER       0
`define AOC_CS_TARGET_X     1
`define AOC_CS_TARGET_Y     3
`define AOC_CS_TARGET_Z     5
// Reset values and counts.
`define AOC_RESET_BYTE      8'h00
`define AOC_FAST_SAMPLES    16
`define AOC_REMAIN_INIT     4'hf
// One g in 12 bit two's complement at the 2g range.
`define AOC_ONE_G_12        12'sh400
// Slow filter shifts: corner bw/1000 and eight times that.
`define AOC_HP_SHIFT_SLOW   8
`define AOC_HP_SHIFT_FAST   5
// Timing: program time in microseconds, derived cycle count at 125 MHz.
`define AOC_PROG_TIME_US    20
`define AOC_CLK_MHZ         125
`define AOC_PROG_CYCLES     (`AOC_PROG_TIME_US * `AOC_CLK_MHZ)
`endif

// >>> verilog/aoc_pkg.sv
package aoc_pkg;
    // Fast compensation sequencer states.
    typedef enum logic [1:0] {
        AOC_FAST_IDLE = 2'b00,
        AOC_FAST_ACC  = 2'b01,
        AOC_FAST_DONE = 2'b10
    } aoc_fast_t;
    // Nonvolatile store sequencer states.
    typedef enum logic [1:0] {
        AOC_NV_IDLE = 2'b00,
        AOC_NV_LOAD = 2'b01,
        AOC_NV_PROG = 2'b10
    } aoc_nv_t;
endpackage : aoc_pkg

// >>> verilog/aoc_comp.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "aoc_params.svh"
module aoc_comp #(
    parameter int SAMPLE_W    = 12,
    parameter int PROG_CYCLES = `AOC_PROG_CYCLES
) (
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [7:0]          reg_rdata,
    input  wire logic                sample_valid,
    input  wire logic [SAMPLE_W-1:0] raw_x,
    input  wire logic [SAMPLE_W-1:0] raw_y,
    input  wire logic [SAMPLE_W-1:0] raw_z,
    input  wire logic [SAMPLE_W-1:0] filt_x,
    input  wire logic [SAMPLE_W-1:0] filt_y,
    input  wire logic [SAMPLE_W-1:0] filt_z,
    output logic      [SAMPLE_W-1:0] comp_raw_x,
    output logic      [SAMPLE_W-1:0] comp_raw_y,
    output logic      [SAMPLE_W-1:0] comp_raw_z,
    output logic      [SAMPLE_W-1:0] comp_filt_x,
    output logic      [SAMPLE_W-1:0] comp_filt_y,
    output logic      [SAMPLE_W-1:0] comp_filt_z,
    output logic                     comp_valid
);

    // The trim arithmetic assumes 12 bit samples at the 2g range.
    initial
    begin
        if (SAMPLE_W != 12) $error("aoc_comp: SAMPLE_W must be 12");
        if (PROG_CYCLES < 1) $error("aoc_comp: PROG_CYCLES must be positive");
    end

    // Saturating 12 bit add used on both output paths.
    function automatic logic [11:0] sat_add(input logic [11:0] a, input logic [11:0] b);
        logic [12:0] s;
        s = {a[11], a} + {b[11], b};
        if (s[12] != s[11]) sat_add = s[12] ? 12'h800 : 12'h7ff;
        else sat_add = s[11:0];
    endfunction : sat_add

    // Widen a byte trim to 12 bits; one byte LSB is four sample LSBs.
    function automatic logic [11:0] widen(input logic [7:0] t);
        widen = {{2{t[7]}}, t, 2'b00};
    endfunction : widen

    // Narrow a wide value to a byte, saturating instead of wrapping.
    function automatic logic [7:0] narrow(input logic [15:0] v);
        logic [13:0] q;
        q = v[15:2];
        if ($signed(q) > 14'sd127) narrow = 8'h7f;
        else if ($signed(q) < -14'sd128) narrow = 8'h80;
        else narrow = q[7:0];
    endfunction : narrow

    // Target decode for a two bit target field.
    function automatic logic [11:0] target_of(input logic [1:0] f);
        case (f)
            2'b01:   target_of = `AOC_ONE_G_12;
            2'b10:   target_of = -`AOC_ONE_G_12;
            default: target_of = 12'h000;
        endcase
    endfunction : target_of

    // Register state.
    logic [7:0]  trim [0:4];
    logic [7:0]  nv_store [0:4];
    logic        nv_unlock;
    logic [3:0]  nv_remain;
    logic [2:0]  slow_en;
    logic [7:0]  setup;
    logic [1:0]  fast_axis;
    logic [1:0]  trig_pend;
    logic [3:0]  fast_cnt;
    logic [15:0] fast_sum;
    logic [15:0] slow_acc [0:2];
    logic [12:0] prog_cnt;
    logic [2:0]  load_idx;
    aoc_pkg::aoc_fast_t fast_st;
    aoc_pkg::aoc_nv_t   nv_st;

    // Bus decode.
    wire wr_nv    = reg_wr && (reg_addr == `AOC_OFS_NVCTRL);
    wire wr_cc    = reg_wr && (reg_addr == `AOC_OFS_COMP_CTRL);
    wire wr_cs    = reg_wr && (reg_addr == `AOC_OFS_COMP_SETUP);
    wire wr_img   = reg_wr && (reg_addr >= `AOC_OFS_TRIM_X) && (reg_addr <= `AOC_OFS_SPARE1);
    wire [2:0] img_idx = 3'(reg_addr - `AOC_OFS_TRIM_X);
    wire clear_req = wr_cc && reg_wdata[`AOC_CC_CLEAR];
    wire [1:0] new_trig = reg_wdata[`AOC_CC_TRIG_LO +: 2];
    wire load_req  = wr_nv && reg_wdata[`AOC_NV_LOAD];
    wire prog_req  = wr_nv && reg_wdata[`AOC_NV_TRIG] && reg_wdata[`AOC_NV_UNLOCK]
                     && nv_unlock && (nv_st == aoc_pkg::AOC_NV_IDLE) && (nv_remain != 4'h0);
    wire fast_busy = (fast_st != aoc_pkg::AOC_FAST_IDLE) || (trig_pend != 2'b00);
    wire nv_ready  = (nv_st != aoc_pkg::AOC_NV_PROG);
    wire load_busy = (nv_st == aoc_pkg::AOC_NV_LOAD);

    // Slow compensation shift depends on the corner bit.
    wire [3:0] hp_shift = setup[`AOC_CS_CORNER] ? 4'(`AOC_HP_SHIFT_FAST) : 4'(`AOC_HP_SHIFT_SLOW);

    // Per-axis raw sample and its target value, and fast average.
    wire [11:0] raw_ax [0:2];
    assign raw_ax[0] = raw_x;
    assign raw_ax[1] = raw_y;
    assign raw_ax[2] = raw_z;
    wire [11:0] sel_raw  = raw_ax[fast_axis - 2'd1];
    wire [11:0] fast_avg = fast_sum[15:4];
    wire [1:0]  tgt_f    = setup[`AOC_CS_TARGET_X + 2*(fast_axis - 2'd1) +: 2];
    wire [11:0] tgt_val  = target_of(tgt_f);
    wire [15:0] fast_diff = 16'($signed(tgt_val)) - 16'($signed(fast_avg));

    // Compensated outputs are registered; sums clamp instead of wrapping.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            comp_raw_x  <= 12'h000;
            comp_raw_y  <= 12'h000;
            comp_raw_z  <= 12'h000;
            comp_filt_x <= 12'h000;
            comp_filt_y <= 12'h000;
            comp_filt_z <= 12'h000;
            comp_valid  <= 1'b0;
        end
        else
        begin
            comp_raw_x  <= sat_add(raw_x, widen(trim[0]));
            comp_raw_y  <= sat_add(raw_y, widen(trim[1]));
            comp_raw_z  <= sat_add(raw_z, widen(trim[2]));
            comp_filt_x <= sat_add(filt_x, widen(trim[0]));
            comp_filt_y <= sat_add(filt_y, widen(trim[1]));
            comp_filt_z <= sat_add(filt_z, widen(trim[2]));
            comp_valid  <= sample_valid;
        end
    end

    // Control fields. The trigger field is write only and is consumed as a pending start.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            slow_en   <= 3'b000;
            setup     <= `AOC_RESET_BYTE;
            nv_unlock <= 1'b0;
            trig_pend <= 2'b00;
        end
        else
        begin
            if (wr_cc) slow_en <= reg_wdata[2:0];
            if (wr_cs) setup <= reg_wdata;
            if (wr_nv) nv_unlock <= reg_wdata[`AOC_NV_UNLOCK];
            if (wr_cc && new_trig != 2'b00 && fast_st == aoc_pkg::AOC_FAST_IDLE)
                trig_pend <= new_trig;
            else if (fast_st == aoc_pkg::AOC_FAST_IDLE)
                trig_pend <= 2'b00;
        end
    end

    // Fast compensation: latch axis, sum 16 samples, then store the result.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            fast_st   <= aoc_pkg::AOC_FAST_IDLE;
            fast_axis <= 2'b00;
            fast_cnt  <= 4'h0;
            fast_sum  <= 16'h0000;
        end
        else
        begin
            case (fast_st)
                aoc_pkg::AOC_FAST_IDLE:
                begin
                    fast_sum <= 16'h0000;
                    fast_cnt <= 4'h0;
                    if (trig_pend != 2'b00)
                    begin
                        fast_axis <= trig_pend;
                        fast_st   <= aoc_pkg::AOC_FAST_ACC;
                    end
                end
                aoc_pkg::AOC_FAST_ACC:
                    if (sample_valid)
                    begin
                        fast_sum <= fast_sum + {{4{sel_raw[11]}}, sel_raw};
                        fast_cnt <= fast_cnt + 4'h1;
                        if (fast_cnt == 4'(`AOC_FAST_SAMPLES - 1))
                            fast_st <= aoc_pkg::AOC_FAST_DONE;
                    end
                aoc_pkg::AOC_FAST_DONE:
                    fast_st <= aoc_pkg::AOC_FAST_IDLE;
                default:
                    fast_st <= aoc_pkg::AOC_FAST_IDLE;
            endcase
        end
    end

    // Slow compensation accumulators: a plain integrator that subtracts the compensated raw output shifted by hp_shift.
    wire [11:0] comp_ax [0:2];
    assign comp_ax[0] = comp_raw_x;
    assign comp_ax[1] = comp_raw_y;
    assign comp_ax[2] = comp_raw_z;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < 3; i++) slow_acc[i] <= 16'h0000;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
                if (!slow_en[i] || clear_req)
                    slow_acc[i] <= 16'h0000;
                else if (comp_valid)
                    slow_acc[i] <= slow_acc[i] - 16'($signed({{4{comp_ax[i][11]}}, comp_ax[i]})
                                   >>> hp_shift);
        end
    end

    // Image registers, nonvolatile store and its sequencer.
    // The load walks one image byte per cycle so busy is visible to software.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < 5; i++) trim[i] <= `AOC_RESET_BYTE;
            for (int i = 0; i < 5; i++) nv_store[i] <= `AOC_RESET_BYTE;
            nv_remain <= `AOC_REMAIN_INIT;
            nv_st     <= aoc_pkg::AOC_NV_LOAD;
            load_idx  <= 3'd0;
            prog_cnt  <= 13'd0;
        end
        else
        begin
            if (wr_img) trim[img_idx] <= reg_wdata;
            if (fast_st == aoc_pkg::AOC_FAST_DONE)
                trim[fast_axis - 2'd1] <= narrow(fast_diff);
            else
                for (int i = 0; i < 3; i++)
                    if (slow_en[i] && comp_valid && !wr_img)
                        trim[i] <= narrow(16'($signed(widen(trim[i])))
                                   + ($signed(slow_acc[i]) >>> 4));
            if (clear_req)
                for (int i = 0; i < 3; i++) trim[i] <= 8'h00;
            case (nv_st)
                aoc_pkg::AOC_NV_IDLE:
                begin
                    load_idx <= 3'd0;
                    if (load_req) nv_st <= aoc_pkg::AOC_NV_LOAD;
                    else if (prog_req)
                    begin
                        nv_st    <= aoc_pkg::AOC_NV_PROG;
                        prog_cnt <= 13'(PROG_CYCLES - 1);
                    end
                end
                aoc_pkg::AOC_NV_LOAD:
                begin
                    trim[load_idx] <= nv_store[load_idx];
                    load_idx <= load_idx + 3'd1;
                    if (load_idx == 3'd4) nv_st <= aoc_pkg::AOC_NV_IDLE;
                end
                aoc_pkg::AOC_NV_PROG:
                begin
                    prog_cnt <= prog_cnt - 13'd1;
                    if (prog_cnt == 13'd0)
                    begin
                        for (int i = 0; i < 5; i++) nv_store[i] <= trim[i];
                        nv_remain <= nv_remain - 4'h1;
                        nv_st <= aoc_pkg::AOC_NV_IDLE;
                    end
                end
                default: nv_st <= aoc_pkg::AOC_NV_IDLE;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero.
    wire [7:0] rd_nv = {nv_remain, load_busy, nv_ready, 1'b0, nv_unlock};
    wire [7:0] rd_cc = {3'b000, !fast_busy, 1'b0, slow_en};
    wire [7:0] rd_mux = (reg_addr == `AOC_OFS_NVCTRL)     ? rd_nv :
                        (reg_addr == `AOC_OFS_COMP_CTRL)  ? rd_cc :
                        (reg_addr == `AOC_OFS_COMP_SETUP) ? setup :
                        ((reg_addr >= `AOC_OFS_TRIM_X) && (reg_addr <= `AOC_OFS_SPARE1))
                                                          ? trim[img_idx] : 8'h00;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn) reg_rdata <= 8'h00;
        else if (reg_rd) reg_rdata <= rd_mux;
    end

    // Ready must be low whenever a fast run is in flight.
    property p_ready_low_busy;
        @(posedge mclk) disable iff (!resetn)
        (fast_st != aoc_pkg::AOC_FAST_IDLE || trig_pend != 2'b00) |-> !rd_cc[`AOC_CC_READY];
    endproperty
    a_ready_low_busy: assert property (p_ready_low_busy) else $error("ready high during run");

    // A clear outside a reload leaves every axis trim at zero.
    property p_clear;
        @(posedge mclk) disable iff (!resetn)
        clear_req |=> (trim[0] == 8'h00 && trim[1] == 8'h00 && trim[2] == 8'h00);
    endproperty
    a_clear: assert property (p_clear) else $error("trim not cleared");

    // Programming holds ready low for at least eight cycles.
    property p_prog_ready;
        @(posedge mclk) disable iff (!resetn)
        prog_req |=> !nv_ready [*8];
    endproperty
    a_prog_ready: assert property (p_prog_ready) else $error("program ready too early");

    // A load request finishes within six cycles.
    property p_load_done;
        @(posedge mclk) disable iff (!resetn)
        (load_req && nv_st == aoc_pkg::AOC_NV_IDLE) |=> load_busy ##[1:6] !load_busy;
    endproperty
    a_load_done: assert property (p_load_done) else $error("reload did not finish");

    // Outputs never wrap: positive plus positive stays non-negative.
    property p_clamp;
        @(posedge mclk) disable iff (!resetn)
        (!raw_x[11] && !trim[0][7]) |=> !comp_raw_x[11];
    endproperty
    a_clamp: assert property (p_clamp) else $error("sum wrapped");

    // A program consumes one remaining cycle.
    property p_remain;
        @(posedge mclk) disable iff (!resetn)
        (nv_st == aoc_pkg::AOC_NV_PROG && prog_cnt == 13'd0) |=> nv_remain == $past(nv_remain) - 4'h1;
    endproperty
    a_remain: assert property (p_remain) else $error("remain count wrong");

    // A trigger drops ready on the next cycle and starts the run one cycle later.
    property p_trig;
        @(posedge mclk) disable iff (!resetn)
        (wr_cc && new_trig != 2'b00 && !fast_busy) |=> fast_busy ##1 (fast_st == aoc_pkg::AOC_FAST_ACC);
    endproperty
    a_trig: assert property (p_trig) else $error("trigger not taken");

    // A write to a spare image byte is kept in the image on the next cycle.
    property p_image_rw;
        @(posedge mclk) disable iff (!resetn)
        (wr_img && img_idx > 3'd2 && nv_st == aoc_pkg::AOC_NV_IDLE) |=> trim[$past(img_idx)] == $past(reg_wdata);
    endproperty
    a_image_rw: assert property (p_image_rw) else $error("spare byte lost");

endmodule : aoc_comp
`default_nettype wire

// >>> bench/tb_aoc_comp.sv
`timescale 1ns/1ps
`default_nettype none
`include "aoc_params.svh"
module tb_aoc_comp;
    localparam int W = 12;
    logic         mclk;
    logic         resetn;
    logic [7:0]   reg_addr;
    logic [7:0]   reg_wdata;
    logic         reg_wr;
    logic         reg_rd;
    logic [7:0]   reg_rdata;
    logic         sample_valid;
    logic [W-1:0] raw_x, raw_y, raw_z, filt_x, filt_y, filt_z;
    logic [W-1:0] comp_raw_x, comp_raw_y, comp_raw_z;
    logic [W-1:0] comp_filt_x, comp_filt_y, comp_filt_z;
    logic         comp_valid;
    int           miscompares;
    int           n_compared;
    logic [7:0]   d;
    logic [7:0]   t0;

    // Programming time shortened so the store write finishes in a few reads.
    aoc_comp #(.SAMPLE_W(W), .PROG_CYCLES(10)) i_aoc_comp (
        .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sample_valid(sample_valid), .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z),
        .filt_x(filt_x), .filt_y(filt_y), .filt_z(filt_z),
        .comp_raw_x(comp_raw_x), .comp_raw_y(comp_raw_y), .comp_raw_z(comp_raw_z),
        .comp_filt_x(comp_filt_x), .comp_filt_y(comp_filt_y), .comp_filt_z(comp_filt_z),
        .comp_valid(comp_valid));

    // Free running 125 MHz clock.
    always #4 mclk = ~mclk;

    task results;
        $display("Comparisons %0d, mismatches %0d.", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    task chk(input bit ok, input string what);
        n_compared++;
        if (!ok)
        begin
            miscompares++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    // The read data is taken just after the edge that follows the strobe.
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    // Polls one status bit, bounded so a stuck flag cannot hang the run.
    task poll(input logic [7:0] a, input int b, input logic val, input int lim);
        int i;
        for (i = 0; i < lim; i++)
        begin
            rd(a, d);
            if (d[b] === val)
                break;
        end
        chk(d[b] === val, "status bit did not settle");
    endtask : poll

    // One sample pulse; outputs are settled just after the capturing edge.
    task smp(input logic [W-1:0] x, y, z, fx, fy, fz);
        @(posedge mclk);
        sample_valid <= 1'b1;
        raw_x  <= x;
        raw_y  <= y;
        raw_z  <= z;
        filt_x <= fx;
        filt_y <= fy;
        filt_z <= fz;
        @(posedge mclk);
        sample_valid <= 1'b0;
        #1;
    endtask : smp

    task t_reset_image;
        int a;
        for (a = 8'h38; a <= 8'h3c; a++)
        begin
            rd(a[7:0], d);
            chk(d === 8'h00, "image not zero after reset");
        end
        rd(8'h33, d);
        chk(d[7:4] === 4'hf, "remaining count wrong");
        for (a = 8'h38; a <= 8'h3c; a++)
            wr(a[7:0], 8'h51 + a[7:0]);
        for (a = 8'h38; a <= 8'h3c; a++)
        begin
            rd(a[7:0], d);
            chk(d === 8'h51 + a[7:0], "image readback");
        end
        wr(8'h35, 8'h5a);
        rd(8'h35, d);
        chk(d === 8'h00, "unmapped read not zero");
    endtask : t_reset_image

    task t_path;
        wr(8'h38, 8'h10);
        wr(8'h39, 8'h7f);
        wr(8'h3a, 8'h80);
        smp(12'h100, 12'h7ff, 12'h800, 12'h020, 12'h7f0, 12'h900);
        chk(comp_valid === 1'b1, "comp valid missing");
        chk(comp_raw_x === 12'h140 && comp_filt_x === 12'h060, "x sum");
        chk(comp_raw_y === 12'h7ff && comp_filt_y === 12'h7ff, "y clamp high");
        chk(comp_raw_z === 12'h800 && comp_filt_z === 12'h800, "z clamp low");
        @(posedge mclk);
        #1;
        chk(comp_valid === 1'b0, "comp valid too long");
        wr(8'h36, 8'h80);
        rd(8'h38, d);
        chk(d === 8'h00, "clear x");
        rd(8'h3a, d);
        chk(d === 8'h00, "clear z");
        rd(8'h3b, d);
        chk(d === 8'h8c, "spare hit by clear");
    endtask : t_path

    // Fast run on one axis: 15 samples keep it busy, the 16th completes it.
    task fast(input logic [1:0] ax, input logic [W-1:0] s, input logic [7:0] a,
              input logic [7:0] exp);
        int i;
        wr(8'h36, {1'b0, ax, 5'h00});
        rd(8'h36, d);
        chk(d[4] === 1'b0 && d[6:5] === 2'b00, "ready high during run");
        // No trim register is written while the run is in flight.
        for (i = 0; i < 15; i++)
            smp(s, s, s, s, s, s);
        rd(8'h36, d);
        chk(d[4] === 1'b0, "done before 16 samples");
        smp(s, s, s, s, s, s);
        poll(8'h36, 4, 1'b1, 8);
        rd(a, d);
        chk(d === exp, "fast result");
    endtask : fast

    task t_fast;
        wr(8'h37, 8'h72);
        rd(8'h37, d);
        chk(d === 8'h72, "setup readback");
        wr(8'h36, 8'h00);
        rd(8'h36, d);
        chk(d[4] === 1'b1, "ready low with no axis");
        // Sample values are scaled for the 2g range, where one g is 0x400.
        fast(2'b01, 12'h100, 8'h38, 8'h7f);
        fast(2'b10, 12'h100, 8'h39, 8'h80);
        fast(2'b11, 12'h040, 8'h3a, 8'hf0);
        rd(8'h38, d);
        chk(d === 8'h7f, "x disturbed by z run");
    endtask : t_fast

    task t_slow;
        int i;
        wr(8'h37, 8'h00);
        wr(8'h36, 8'h81);
        // Samples arrive at the full rate; no low power mode is modelled.
        for (i = 0; i < 32; i++)
            smp(12'h100, 12'h100, 12'h100, 12'h100, 12'h100, 12'h100);
        rd(8'h38, t0);
        rd(8'h39, d);
        chk(d === 8'h00, "slow acted on disabled axis");
        chk($signed(t0) < 0, "slow moved away from zero");
        wr(8'h37, 8'h01);
        wr(8'h36, 8'h81);
        for (i = 0; i < 32; i++)
            smp(12'h100, 12'h100, 12'h100, 12'h100, 12'h100, 12'h100);
        rd(8'h38, d);
        chk($signed(d) < 0 && $signed(d) < $signed(t0), "corner bit ineffective");
        wr(8'h36, 8'h80);
    endtask : t_slow

    task t_nvm;
        int a;
        for (a = 8'h38; a <= 8'h3c; a++)
            wr(a[7:0], 8'h11 * (a[7:0] - 8'h37));
        wr(8'h33, 8'h01);
        wr(8'h33, 8'h03);
        rd(8'h33, d);
        chk(d[2] === 1'b0, "program ready high while writing");
        // Only status reads happen while the store is being written.
        poll(8'h33, 2, 1'b1, 30);
        rd(8'h33, d);
        chk(d[7:4] === 4'he, "remaining not decremented");
        for (a = 8'h38; a <= 8'h3c; a++)
            wr(a[7:0], 8'hee);
        wr(8'h33, 8'h08);
        rd(8'h33, d);
        chk(d[3] === 1'b1, "load busy missing");
        poll(8'h33, 3, 1'b0, 10);
        for (a = 8'h38; a <= 8'h3c; a++)
        begin
            rd(a[7:0], d);
            chk(d === 8'h11 * (a[7:0] - 8'h37), "reloaded image");
        end
    endtask : t_nvm

    // Watchdog sized well above the few hundred cycles the tests need.
    initial
    begin
        #(50000 * 8);
        miscompares++;
        results;
    end

    initial
    begin
        mclk = 1'b0;
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sample_valid = 1'b0;
        {raw_x, raw_y, raw_z, filt_x, filt_y, filt_z} = '0;
        miscompares = 0;
        n_compared = 0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        poll(8'h33, 3, 1'b0, 10);
        t_reset_image;
        t_path;
        t_fast;
        t_slow;
        t_nvm;
        results;
    end
endmodule : tb_aoc_comp
`default_nettype wire
